//--- cam_block.sv
// Content-addressable memory end: 32 words, ternary compare
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// (RQ1) Store 32 words of 32 bits, compare all
// (RQ2) Each stored bit definite or don't-care
// (RQ3) Don't-care bits never block a match
// (RQ4) Encoded mode returns matching word index
// (RQ5) Unencoded mode drives 16 one-hot result lines; here one line per matching word, so several or none can be high
// (RQ6) Unencoded result spans two cycles, both captured
// (RQ7) Writer avoids duplicates when using encoded output
// (RQ8) Unencoded mode reports all matches together
// (RQ9) Contents preset at configuration, writable later
// (RQ10) Plain write takes two cycles, request held
// (RQ11) Don't-care write takes a third cycle
// (RQ12) No match: no lines high, miss signalled
module cam_block (
    input  wire logic mclk,
    input  wire logic rst,
    cam_link_if.dev   link
);
    import cam_pkg::*;

    // ------------------------------------------------------------
    // Types and storage
    // ------------------------------------------------------------
    // One-hot codes, one bit per state
    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0001,
        ST_DATA  = 4'b0010,
        ST_MASK  = 4'b0100,
        ST_UPPER = 4'b1000
    } cam_state_t;

    cam_state_t state_reg;
    cam_state_t state_next;
    word_t      data_mem [CAM_WORDS];
    word_t      care_mem [CAM_WORDS];
    match_t     match_vec;
    half_t      upper_reg;
    logic       masked_wr;
    logic       srch_take;

    // ------------------------------------------------------------
    // Compare functions
    // ------------------------------------------------------------
    function automatic logic word_hit(input word_t stored,
                                      input word_t care,
                                      input word_t key);
        // Care bit 1 compares, 0 is a don't-care
        word_hit = ((stored ^ key) & care) == '0; // see (RQ3)
    endfunction : word_hit

    function automatic idx_t first_hit(input match_t m);
        // Lowest index wins; duplicates show on res_multi and on the res_lines beats
        first_hit = '0;
        for (int i = CAM_WORDS - 1; i >= 0; i--) begin
            if (m[i]) begin
                first_hit = idx_t'(i);
            end
        end
    endfunction : first_hit

    function automatic logic many_hits(input match_t m);
        // Clearing the lowest set bit leaves something on two or more
        many_hits = (m & (m - match_t'(1))) != '0;
    endfunction : many_hits

    // ------------------------------------------------------------
    // Parallel compare of every word
    // ------------------------------------------------------------
    // All words at once; no priority at this stage
    always_comb begin
        for (int i = 0; i < CAM_WORDS; i++) begin
            match_vec[i] = word_hit(data_mem[i], care_mem[i],
                                    link.srch_key); // see (RQ1)
        end
    end

    // ------------------------------------------------------------
    // Handshakes
    // ------------------------------------------------------------
    // Any cleared care bit costs the write a third cycle
    assign masked_wr  = link.wr_care != CARE_ALL;
    // Writes win over searches; searches wait while ready is low
    assign link.srch_ready = (state_reg == ST_IDLE) && !link.wr_req;
    assign srch_take  = link.srch_ready && link.srch_req;
    // Done marks the last write cycle; the user drops its request
    // on the edge that ends it, so no word is written twice
    assign link.wr_done =
        ((state_reg == ST_DATA) && !masked_wr) ||
        (state_reg == ST_MASK); // see (RQ10) see (RQ11)

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (link.wr_req) begin
                    state_next = ST_DATA;
                end else if (srch_take && link.srch_unenc) begin
                    state_next = ST_UPPER;
                end
            end
            ST_DATA: begin
                state_next = masked_wr ? ST_MASK : ST_IDLE; // see (RQ11)
            end
            ST_MASK: begin
                state_next = ST_IDLE;
            end
            // Second beat of an unencoded result
            ST_UPPER: begin
                state_next = ST_IDLE;
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_reg <= ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // ------------------------------------------------------------
    // Word storage
    // ------------------------------------------------------------
    // Reset stands in for configuration preload
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < CAM_WORDS; i++) begin
                data_mem[i] <= INIT_DATA; // see (RQ9)
            end
        end else if (state_reg == ST_DATA) begin
            data_mem[link.wr_addr] <= link.wr_data; // see (RQ9)
        end
    end

    // ------------------------------------------------------------
    // Care masks
    // ------------------------------------------------------------
    // Plain write sets full care so an old mask never lingers
    // Masked word sees new data under the old mask for one cycle;
    // harmless, since searches are held off until the write ends
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < CAM_WORDS; i++) begin
                care_mem[i] <= INIT_CARE;
            end
        end else if (state_reg == ST_DATA && !masked_wr) begin
            care_mem[link.wr_addr] <= CARE_ALL;
        end else if (state_reg == ST_MASK) begin
            care_mem[link.wr_addr] <= link.wr_care; // see (RQ2)
        end
    end

    // ------------------------------------------------------------
    // Result beats
    // ------------------------------------------------------------
    // One pulse per beat; upper flag only on the second
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            link.res_valid <= 1'b0;
            link.res_upper <= 1'b0;
        end else begin
            link.res_valid <= srch_take || (state_reg == ST_UPPER);
            link.res_upper <= (state_reg == ST_UPPER); // see (RQ6)
        end
    end

    // ------------------------------------------------------------
    // Result summary
    // ------------------------------------------------------------
    // Held until the next take, so the reader may sample late
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            link.res_hit   <= 1'b0;
            link.res_multi <= 1'b0;
            link.res_addr  <= '0;
        end else if (srch_take) begin
            link.res_hit   <= match_vec != '0; // see (RQ12)
            link.res_multi <= many_hits(match_vec); // see (RQ8)
            link.res_addr  <= first_hit(match_vec); // see (RQ4)
        end
    end

    // ------------------------------------------------------------
    // Result lines
    // ------------------------------------------------------------
    // Upper half latched at the take; the key may move after it
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            link.res_lines <= '0;
            upper_reg      <= '0;
        end else if (srch_take) begin
            // Lower half first; encoded mode also shows it
            link.res_lines <= match_vec[CAM_HALF-1:0]; // see (RQ5)
            upper_reg      <= match_vec[CAM_WORDS-1:CAM_HALF];
        end else if (state_reg == ST_UPPER) begin
            link.res_lines <= upper_reg; // see (RQ6)
        end
    end
endmodule : cam_block
`default_nettype wire

//--- cam_pkg.sv
// Shared constants and types for the content-addressable memory link
package cam_pkg;
    // ------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------
    localparam int unsigned CAM_WORDS = 32;
    localparam int unsigned CAM_WIDTH = 32;
    localparam int unsigned CAM_HALF  = 16;
    localparam int unsigned CAM_IDX_W = 5;
    // ------------------------------------------------------------
    // Write timing, in clock cycles
    // ------------------------------------------------------------
    localparam int unsigned WR_CYCLES_PLAIN  = 2;
    localparam int unsigned WR_CYCLES_MASKED = 3;
    // ------------------------------------------------------------
    // Configuration-time contents; care bit 1 = compared
    // ------------------------------------------------------------
    localparam logic [CAM_WIDTH-1:0] INIT_DATA = 32'h0000_0000;
    localparam logic [CAM_WIDTH-1:0] INIT_CARE = 32'hFFFF_FFFF;
    localparam logic [CAM_WIDTH-1:0] CARE_ALL  = 32'hFFFF_FFFF;

    typedef logic [CAM_WIDTH-1:0] word_t;
    typedef logic [CAM_IDX_W-1:0] idx_t;
    typedef logic [CAM_HALF-1:0]  half_t;
    typedef logic [CAM_WORDS-1:0] match_t;
endpackage : cam_pkg

//--- cam_link_if.sv
// Link between the memory block and the fabric user logic
`timescale 1ns/100ps
`default_nettype none
interface cam_link_if;
    import cam_pkg::*;
    logic  wr_req;
    idx_t  wr_addr;
    word_t wr_data;
    word_t wr_care;
    logic  wr_done;
    logic  srch_req;
    word_t srch_key;
    logic  srch_unenc;
    logic  srch_ready;
    logic  res_valid;
    logic  res_hit;
    logic  res_multi;
    idx_t  res_addr;
    half_t res_lines;
    logic  res_upper;

    modport dev (
        input  wr_req, wr_addr, wr_data, wr_care, srch_req, srch_key,
               srch_unenc,
        output wr_done, srch_ready, res_valid, res_hit, res_multi,
               res_addr, res_lines, res_upper
    );
    modport user (
        output wr_req, wr_addr, wr_data, wr_care, srch_req, srch_key,
               srch_unenc,
        input  wr_done, srch_ready, res_valid, res_hit, res_multi,
               res_addr, res_lines, res_upper
    );
endinterface : cam_link_if
`default_nettype wire

//--- cam_user.sv
// Fabric user end: drives writes and searches, gathers results
`timescale 1ns/100ps
`default_nettype none
module cam_user (
    input  wire logic            mclk,
    input  wire logic            rst,
    input  wire logic            cmd_write,
    input  wire logic            cmd_search,
    input  wire cam_pkg::idx_t   cmd_addr,
    input  wire cam_pkg::word_t  cmd_data,
    input  wire cam_pkg::word_t  cmd_care,
    input  wire logic            cmd_unenc,
    output logic                 cmd_ready,
    output logic                 out_valid,
    output logic                 out_hit,
    output logic                 out_multi,
    output cam_pkg::idx_t        out_addr,
    output cam_pkg::match_t      out_match,
    cam_link_if.user             link
);
    import cam_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        U_IDLE  = 4'b0001,
        U_WRITE = 4'b0010,
        U_ASK   = 4'b0100,
        U_WAIT  = 4'b1000
    } user_state_t;

    user_state_t state_reg;
    logic        unenc_reg;

    assign cmd_ready = state_reg == U_IDLE;

    // ------------------------------------------------------------
    // Request side
    // ------------------------------------------------------------
    // Write request and data stay put until the block says done; a search request stays until ready
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_reg       <= U_IDLE;
            unenc_reg       <= 1'b0;
            link.wr_req     <= 1'b0;
            link.wr_addr    <= '0;
            link.wr_data    <= '0;
            link.wr_care    <= CARE_ALL;
            link.srch_req   <= 1'b0;
            link.srch_key   <= '0;
            link.srch_unenc <= 1'b0;
        end else begin
            case (state_reg)
                U_IDLE: begin
                    if (cmd_write) begin
                        link.wr_req  <= 1'b1; // see (RQ10)
                        link.wr_addr <= cmd_addr;
                        link.wr_data <= cmd_data;
                        link.wr_care <= cmd_care;
                        state_reg    <= U_WRITE;
                    end else if (cmd_search) begin
                        link.srch_req   <= 1'b1;
                        link.srch_key   <= cmd_data;
                        link.srch_unenc <= cmd_unenc;
                        unenc_reg       <= cmd_unenc;
                        state_reg       <= U_ASK;
                    end
                end
                U_WRITE: begin
                    if (link.wr_done) begin // see (RQ11)
                        link.wr_req <= 1'b0;
                        state_reg   <= U_IDLE;
                    end
                end
                U_ASK: begin
                    if (link.srch_ready) begin
                        link.srch_req <= 1'b0;
                        state_reg     <= U_WAIT;
                    end
                end
                U_WAIT: begin
                    if (link.res_valid &&
                        (!unenc_reg || link.res_upper)) begin
                        state_reg <= U_IDLE;
                    end
                end
                default: begin
                    state_reg <= U_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Result capture; both halves needed in unencoded mode
    // ------------------------------------------------------------
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            out_valid <= 1'b0;
            out_hit   <= 1'b0;
            out_multi <= 1'b0;
            out_addr  <= '0;
            out_match <= '0;
        end else begin
            out_valid <= 1'b0;
            if (state_reg == U_WAIT && link.res_valid) begin
                if (!link.res_upper) begin
                    out_hit   <= link.res_hit;
                    out_multi <= link.res_multi;
                    out_addr  <= link.res_addr;
                    out_match <= {{CAM_HALF{1'b0}}, link.res_lines};
                    out_valid <= !unenc_reg;
                end else begin
                    out_match[CAM_WORDS-1:CAM_HALF] <=
                        link.res_lines; // see (RQ6)
                    out_valid <= 1'b1;
                end
            end
        end
    end
endmodule : cam_user
`default_nettype wire

//--- cam_link_monitor.sv
// Assertions on the link between memory block and user end
`timescale 1ns/100ps
`default_nettype none
module cam_link_monitor (
    input wire logic           mclk,
    input wire logic           rst,
    input wire logic           wr_req,
    input wire cam_pkg::word_t wr_care,
    input wire logic           wr_done,
    input wire logic           srch_req,
    input wire logic           srch_unenc,
    input wire logic           srch_ready,
    input wire logic           res_valid,
    input wire logic           res_hit,
    input wire logic           res_multi,
    input wire cam_pkg::half_t res_lines,
    input wire logic           res_upper
);
    import cam_pkg::*;
    // ----------------------------------------
    // Link timing
    // ----------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    property p_wr_plain;
        $rose(wr_req) && wr_care == CARE_ALL
            |-> !wr_done ##1 wr_done ##1 !wr_done;
    endproperty
    a_wr_plain: assert property (p_wr_plain)
        else $error("plain write not done in two cycles");
    property p_wr_masked;
        $rose(wr_req) && wr_care != CARE_ALL
            |-> (!wr_done)[*2] ##1 wr_done;
    endproperty
    a_wr_masked: assert property (p_wr_masked)
        else $error("masked write not done in three cycles");
    property p_done_req;
        wr_done |-> wr_req;
    endproperty
    a_done_req: assert property (p_done_req)
        else $error("write done without request");
    property p_wr_block;
        wr_req |-> !srch_ready;
    endproperty
    a_wr_block: assert property (p_wr_block)
        else $error("search offered during write");
    property p_enc;
        srch_req && srch_ready && !srch_unenc |=> res_valid && !res_upper;
    endproperty
    a_enc: assert property (p_enc)
        else $error("encoded result late");
    property p_unenc;
        srch_req && srch_ready && srch_unenc
            |=> res_valid && !res_upper && !srch_ready
            ##1 res_valid && res_upper;
    endproperty
    a_unenc: assert property (p_unenc)
        else $error("unencoded result not two beats");
    property p_miss;
        res_valid && !res_hit |-> res_lines == '0 && !res_multi;
    endproperty
    a_miss: assert property (p_miss)
        else $error("lines raised on a miss");
    property p_upper;
        res_upper |-> res_valid && $past(res_valid);
    endproperty
    a_upper: assert property (p_upper)
        else $error("upper beat without lower beat");
    c_masked: cover property ($rose(wr_req) && wr_care != CARE_ALL);
    c_multi: cover property (res_valid && res_multi);
    c_miss: cover property (res_valid && !res_hit && res_upper);
endmodule : cam_link_monitor
`default_nettype wire

//--- content_addressable_memory_32x32_tb.sv
// Testbench joining the memory block and its user end
`timescale 1ns/100ps
`default_nettype none
module content_addressable_memory_32x32_tb;
    import cam_pkg::*;
    logic   mclk;
    logic   rst;
    logic   cmd_write;
    logic   cmd_search;
    idx_t   cmd_addr;
    word_t  cmd_data;
    word_t  cmd_care;
    logic   cmd_unenc;
    logic   cmd_ready;
    logic   out_valid;
    logic   out_hit;
    logic   out_multi;
    idx_t   out_addr;
    match_t out_match;
    int     fails;
    int     n_tests;
    int     i;
    cam_link_if link ();
    cam_block u_cam_block (.mclk, .rst, .link);
    cam_user u_cam_user (.mclk, .rst, .cmd_write, .cmd_search, .cmd_addr,
        .cmd_data, .cmd_care, .cmd_unenc, .cmd_ready, .out_valid, .out_hit,
        .out_multi, .out_addr, .out_match, .link);
    cam_link_monitor u_cam_link_monitor (.mclk, .rst,
        .wr_req(link.wr_req), .wr_care(link.wr_care),
        .wr_done(link.wr_done), .srch_req(link.srch_req),
        .srch_unenc(link.srch_unenc), .srch_ready(link.srch_ready),
        .res_valid(link.res_valid), .res_hit(link.res_hit),
        .res_multi(link.res_multi), .res_lines(link.res_lines),
        .res_upper(link.res_upper));
    // ----------------------------------------
    // Access tasks
    // ----------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input idx_t a, input word_t d, input word_t c);
        int k;
        for (k = 0; k < 20 && !cmd_ready; k++) @(negedge mclk);
        cmd_addr = a;
        cmd_data = d;
        cmd_care = c;
        cmd_write = 1'b1;
        @(negedge mclk);
        cmd_write = 1'b0;
        for (k = 0; k < 20 && !cmd_ready; k++) @(negedge mclk);
        chk(k, c == CARE_ALL ? WR_CYCLES_PLAIN : WR_CYCLES_MASKED);
    endtask : wr
    // Expected address is only meaningful on a hit
    task automatic srch(input word_t key, input logic u, input logic h,
                        input logic m, input idx_t a, input match_t mt);
        int k;
        for (k = 0; k < 20 && !cmd_ready; k++) @(negedge mclk);
        cmd_data = key;
        cmd_unenc = u;
        cmd_search = 1'b1;
        @(negedge mclk);
        cmd_search = 1'b0;
        for (k = 0; k < 20 && !out_valid; k++) @(negedge mclk);
        chk(k, u ? 3 : 2);
        chk(out_hit, h);
        chk(out_multi, m);
        if (h) chk(out_addr, a);
        if (u) chk(out_match, mt);
        @(negedge mclk);
    endtask : srch
    task automatic conclude;
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : conclude
    // ----------------------------------------
    // Clock, watchdog and sequence
    // ----------------------------------------
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    // Tests need a few hundred cycles; 4000 leaves ample margin
    initial begin
        #20000;
        fails++;
        conclude();
    end
    initial begin
        fails = 0;
        n_tests = 0;
        rst = 1'b1;
        cmd_write = 1'b0;
        cmd_search = 1'b0;
        cmd_addr = '0;
        cmd_data = '0;
        cmd_care = CARE_ALL;
        cmd_unenc = 1'b0;
        repeat (5) @(negedge mclk);
        rst = 1'b0;
        srch(32'h0, 1'b1, 1'b1, 1'b1, 5'h00, 32'hFFFF_FFFF);
        for (i = 0; i < 32; i++) begin
            wr(i[4:0], 32'hA500_0000 | word_t'(i), CARE_ALL);
        end
        for (i = 0; i < 32; i += 7) begin
            srch(32'hA500_0000 | word_t'(i), i[0], 1'b1, 1'b0, i[4:0],
                 match_t'(1) << i);
        end
        srch(32'h1234_5678, 1'b1, 1'b0, 1'b0, 5'h00, '0);
        // Low half compared only, upper bits free
        wr(5'h0C, 32'h0000_BEEF, 32'h0000_FFFF);
        srch(32'h1234_BEEF, 1'b1, 1'b1, 1'b0, 5'h0C, 32'h0000_1000);
        srch(32'hFFFF_BEEF, 1'b0, 1'b1, 1'b0, 5'h0C, '0);
        srch(32'hA500_000C, 1'b0, 1'b0, 1'b0, 5'h00, '0);
        wr(5'h14, 32'hA500_0005, CARE_ALL);
        srch(32'hA500_0005, 1'b1, 1'b1, 1'b1, 5'h05, 32'h0010_0020);
        srch(32'hA500_0005, 1'b0, 1'b1, 1'b1, 5'h05, '0);
        wr(5'h0C, 32'hA500_000C, CARE_ALL);
        srch(32'h1234_BEEF, 1'b1, 1'b0, 1'b0, 5'h00, '0);
        rst = 1'b1;
        @(negedge mclk);
        rst = 1'b0;
        srch(32'h0, 1'b1, 1'b1, 1'b1, 5'h00, 32'hFFFF_FFFF);
        conclude();
    end
endmodule : content_addressable_memory_32x32_tb
`default_nettype wire
